/* pkg/fsr_pkg.sv */
// Constants, types and state encodings shared by the flash security-read and mode/reset block.
// Behaviour
// - Secure read: command, three address bytes, dummy byte.
// - Secure read data shifts out on falling edges.
// - Start anywhere; address increments after each byte.
// - Low ten address bits wrap 3FF to 000.
// - Four-line mode accepts set-read-parameters command.
// - Dummy select gives 4, 4, 6, 8 clocks.
// - Wrap select gives 8, 16, 32, 64 bytes.
// - Wrap bits from wrap command survive mode entry.
// - Wrapped burst read wraps inside its window.
// - Enable command enters four-line command mode.
// - Mode switch keeps dummy select and wrap.
// - Disable command returns to single-line mode.
// - Accepted reset restores all volatile power-on defaults.
// - Reset needs enable frame then reset frame.
// - Device stays busy 30us, or 12ms after erase.
// - Delivered security register bytes read FFH.
package fsr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 125;
  localparam int RST_TIME_US = 30;
  localparam int RST_E_TIME_MS = 12;
  localparam int RST_CYCLES = RST_TIME_US * CLK_FREQ_MHZ;
  localparam int RST_E_CYCLES = RST_E_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int BUSY_CNT_W = 21;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SEC_READ = 8'h48;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_BURST_WRAP = 8'h0C;
  localparam logic [7:0] CMD_SET_PARAM = 8'hC0;
  localparam logic [7:0] CMD_SET_WRAP = 8'h77;
  localparam logic [7:0] CMD_QPI_ON = 8'h38;
  localparam logic [7:0] CMD_QPI_OFF = 8'hFF;
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;

  // ----------------------------------------------------------------
  // Frame phase lengths, as the index of the last serial edge
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_LAST_SPI = 6'h07;
  localparam logic [5:0] CMD_LAST_QPI = 6'h01;
  localparam logic [5:0] ADDR_LAST_SPI = 6'h17;
  localparam logic [5:0] ADDR_LAST_QPI = 6'h05;
  localparam logic [5:0] SEC_DUMMY_LAST = 6'h07;
  localparam logic [5:0] DUMMY_LAST_4 = 6'h03;
  localparam logic [5:0] DUMMY_LAST_6 = 6'h05;
  localparam logic [5:0] DUMMY_LAST_8 = 6'h07;
  localparam logic [5:0] BYTE_LAST_SPI = 6'h07;
  localparam logic [5:0] BYTE_LAST_QPI = 6'h01;
  localparam logic [5:0] PARAM_LAST_C0 = 6'h01;
  localparam logic [5:0] PARAM_LAST_WRAP = 6'h07;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int P_DSEL_LSB = 4;
  localparam int P_WLEN_LSB = 0;
  localparam int W_WLEN_LSB = 5;
  localparam int W_DIS_BIT = 4;
  localparam int SEC_SEL_LSB = 12;
  localparam int SEC_OFF_W = 10;
  localparam int SEC_IDX_W = 12;
  localparam int SEC_DEPTH = 4096;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [5:0] WRAP_MASK_8 = 6'h07;
  localparam logic [5:0] WRAP_MASK_16 = 6'h0F;
  localparam logic [5:0] WRAP_MASK_32 = 6'h1F;
  localparam logic [5:0] WRAP_MASK_64 = 6'h3F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FSR_ST_CMD = 6'h01,
    FSR_ST_ADDR = 6'h02,
    FSR_ST_DUMMY = 6'h04,
    FSR_ST_DATA = 6'h08,
    FSR_ST_PARAM = 6'h10,
    FSR_ST_IGNORE = 6'h20
  } fsr_state_t;

  typedef struct packed {
    logic four_line_command_mode;
    logic [1:0] dsel;
    logic [1:0] wlen;
    logic wrap_dis;
  } fsr_mode_t;

  localparam fsr_mode_t MODE_RST = '{four_line_command_mode: 1'b0, dsel: 2'h0, wlen: 2'h0, wrap_dis: 1'b1};

  typedef struct packed {
    fsr_state_t state;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [23:0] sh_in;
    logic [23:0] addr;
    logic wrap;
    logic src_sec;
    logic [7:0] sh_out;
    logic dout_en;
  } fsr_frame_t;

  typedef struct packed {
    fsr_mode_t mode;
    logic armed;
    logic rst_tog;
    logic busy_s1;
    logic busy_s2;
  } fsr_cfg_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe;
  } fsr_pins_t;

  typedef struct packed {
    logic [2:0] tog_s;
    fsr_mode_t mode_s1;
    fsr_mode_t mode_s2;
    fsr_mode_t mode_s3;
    fsr_mode_t mode_out;
    logic busy;
    logic [BUSY_CNT_W-1:0] cnt;
    logic soft_rst;
  } fsr_core_t;

endpackage

/* hw/fsr_secreg_mem.sv */
// Security register storage: written from the core clock, read on the serial clock.
`timescale 1ns/100ps
module fsr_secreg_mem (
  input wire logic wr_clk_in,
  input wire logic wr_en_in,
  input wire logic [fsr_pkg::SEC_IDX_W-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_clk_in,
  input wire logic [fsr_pkg::SEC_IDX_W-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem [fsr_pkg::SEC_DEPTH];

  // ----------------------------------------------------------------
  // Delivered state
  // ----------------------------------------------------------------
  // Every byte starts erased, so an untouched register reads all ones.
  initial begin
    for (int i = 0; i < fsr_pkg::SEC_DEPTH; i++) begin
      mem[i] = fsr_pkg::ERASED_BYTE;
    end
  end

  // Program path from the device core.
  always_ff @(posedge wr_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read; the caller presents the address one edge early.
  always_ff @(posedge rd_clk_in) begin
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

/* hw/fsr_top.sv */
// Serial flash command logic: security read, four-line mode, read parameters and soft reset.
`timescale 1ns/100ps
module fsr_top #(
  parameter int unsigned RST_E_CYCLES = fsr_pkg::RST_E_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  output logic [23:0] array_addr_out,
  input wire logic [7:0] array_data_in,
  input wire logic erase_active_in,
  input wire logic secreg_wr_en_in,
  input wire logic [fsr_pkg::SEC_IDX_W-1:0] secreg_wr_addr_in,
  input wire logic [7:0] secreg_wr_data_in,
  output logic busy_out,
  output logic soft_reset_out,
  output logic four_line_command_mode_out,
  output logic [1:0] dummy_clock_select_out,
  output logic [1:0] wrap_length_select_out,
  output logic wrap_disabled_out
);

  fsr_pkg::fsr_frame_t fr_reg, fr_next;
  fsr_pkg::fsr_cfg_t cf_reg, cf_next;
  fsr_pkg::fsr_pins_t pin_reg, pin_next;
  fsr_pkg::fsr_core_t core_reg, core_next;
  logic frame_rst;
  logic [7:0] sec_rdata;
  logic [fsr_pkg::SEC_IDX_W-1:0] sec_rd_idx;

  // Deselect ends every frame without needing a serial edge after it.
  assign frame_rst = rst_in | cs_n_in;
  assign sec_rd_idx = {fr_reg.addr[fsr_pkg::SEC_SEL_LSB+1:fsr_pkg::SEC_SEL_LSB],
                       fr_reg.addr[fsr_pkg::SEC_OFF_W-1:0]};

  // ----------------------------------------------------------------
  // Security register storage
  // ----------------------------------------------------------------
  fsr_secreg_mem u_mem (
    .wr_clk_in(clk_in),
    .wr_en_in(secreg_wr_en_in),
    .wr_addr_in(secreg_wr_addr_in),
    .wr_data_in(secreg_wr_data_in),
    .rd_clk_in(sclk_in),
    .rd_addr_in(sec_rd_idx),
    .rd_data_out(sec_rdata)
  );

  // ----------------------------------------------------------------
  // Link side: command decode and data shifting on the serial clock
  // ----------------------------------------------------------------
  // One decode feeds both the per-frame state and the mode state that
  // outlives frames; they differ only in which reset clears them.
  always_comb begin
    logic q;
    logic [23:0] sh1;
    logic [23:0] sh4;
    logic [23:0] sh_sel;
    logic [7:0] cmd_byte;
    logic [7:0] rd_byte;
    logic [5:0] mask;
    logic [5:0] inc6;
    logic [23:0] next_addr;
    logic [5:0] dummy_last;
    logic [5:0] byte_last;
    mask = fsr_pkg::WRAP_MASK_8;
    next_addr = fr_reg.addr;
    dummy_last = fsr_pkg::DUMMY_LAST_4;
    q = cf_reg.mode.four_line_command_mode;
    sh1 = {fr_reg.sh_in[22:0], io_in[0]};
    sh4 = {fr_reg.sh_in[19:0], io_in};
    sh_sel = q ? sh4 : sh1;
    cmd_byte = sh_sel[7:0];
    rd_byte = fr_reg.src_sec ? sec_rdata : array_data_in;
    byte_last = q ? fsr_pkg::BYTE_LAST_QPI : fsr_pkg::BYTE_LAST_SPI;
    fr_next = fr_reg;
    cf_next = cf_reg;
    cf_next.busy_s1 = core_reg.busy;
    cf_next.busy_s2 = cf_reg.busy_s1;

    // Wrap window mask from the wrap length select.
    unique case (cf_reg.mode.wlen)
      2'h0: mask = fsr_pkg::WRAP_MASK_8;
      2'h1: mask = fsr_pkg::WRAP_MASK_16;
      2'h2: mask = fsr_pkg::WRAP_MASK_32;
      2'h3: mask = fsr_pkg::WRAP_MASK_64;
    endcase

    // Dummy edges: fixed byte for security read, selectable otherwise.
    if (fr_reg.src_sec) begin
      dummy_last = fsr_pkg::SEC_DUMMY_LAST;
    end else begin
      unique case (cf_reg.mode.dsel)
        2'h2: dummy_last = fsr_pkg::DUMMY_LAST_6;
        2'h3: dummy_last = fsr_pkg::DUMMY_LAST_8;
        2'h0, 2'h1: dummy_last = fsr_pkg::DUMMY_LAST_4;
      endcase
    end

    // Address after the byte now being loaded.
    inc6 = fr_reg.addr[5:0] + 6'h01;
    if (fr_reg.src_sec) begin
      next_addr = {fr_reg.addr[23:fsr_pkg::SEC_OFF_W],
                   fr_reg.addr[fsr_pkg::SEC_OFF_W-1:0] + 10'h001};
    end else if (fr_reg.wrap) begin
      next_addr = {fr_reg.addr[23:6], (fr_reg.addr[5:0] & ~mask) | (inc6 & mask)};
    end else begin
      next_addr = fr_reg.addr + 24'h000001;
    end

    unique case (fr_reg.state)
      fsr_pkg::FSR_ST_CMD: begin
        fr_next.sh_in = sh_sel;
        fr_next.cnt = fr_reg.cnt + 6'h01;
        if (fr_reg.cnt == (q ? fsr_pkg::CMD_LAST_QPI : fsr_pkg::CMD_LAST_SPI)) begin
          fr_next.cnt = 6'h00;
          fr_next.cmd = cmd_byte;
          fr_next.state = fsr_pkg::FSR_ST_IGNORE;
          // Nothing is decoded during the recovery period after a reset.
          if (!cf_reg.busy_s2) begin
            cf_next.armed = 1'b0;
            if (cmd_byte == fsr_pkg::CMD_SEC_READ && !q) begin
              fr_next.state = fsr_pkg::FSR_ST_ADDR;
              fr_next.src_sec = 1'b1;
            end else if ((cmd_byte == fsr_pkg::CMD_FAST_READ || cmd_byte == fsr_pkg::CMD_BURST_WRAP) && q) begin
              fr_next.state = fsr_pkg::FSR_ST_ADDR;
              fr_next.wrap = (cmd_byte == fsr_pkg::CMD_BURST_WRAP);
            end else if ((cmd_byte == fsr_pkg::CMD_SET_PARAM && q) || (cmd_byte == fsr_pkg::CMD_SET_WRAP && !q)) begin
              fr_next.state = fsr_pkg::FSR_ST_PARAM;
            end else if (cmd_byte == fsr_pkg::CMD_QPI_ON && !q) begin
              cf_next.mode.four_line_command_mode = 1'b1;
            end else if (cmd_byte == fsr_pkg::CMD_QPI_OFF && q) begin
              cf_next.mode.four_line_command_mode = 1'b0;
            end else if (cmd_byte == fsr_pkg::CMD_RST_EN) begin
              cf_next.armed = 1'b1;
            end else if (cmd_byte == fsr_pkg::CMD_RST && cf_reg.armed) begin
              cf_next.mode = fsr_pkg::MODE_RST;
              cf_next.rst_tog = ~cf_reg.rst_tog;
            end
          end
        end
      end
      fsr_pkg::FSR_ST_ADDR: begin
        fr_next.sh_in = sh_sel;
        fr_next.cnt = fr_reg.cnt + 6'h01;
        if (fr_reg.cnt == (q ? fsr_pkg::ADDR_LAST_QPI : fsr_pkg::ADDR_LAST_SPI)) begin
          fr_next.addr = sh_sel;
          fr_next.cnt = 6'h00;
          fr_next.state = fsr_pkg::FSR_ST_DUMMY;
        end
      end
      fsr_pkg::FSR_ST_DUMMY: begin
        fr_next.cnt = fr_reg.cnt + 6'h01;
        if (fr_reg.cnt == dummy_last) begin
          fr_next.state = fsr_pkg::FSR_ST_DATA;
          fr_next.sh_out = rd_byte;
          fr_next.addr = next_addr;
          fr_next.dout_en = 1'b1;
          fr_next.cnt = 6'h00;
        end
      end
      fsr_pkg::FSR_ST_DATA: begin
        // The read port has a whole byte time to fetch the next byte.
        if (fr_reg.cnt == byte_last) begin
          fr_next.sh_out = rd_byte;
          fr_next.addr = next_addr;
          fr_next.cnt = 6'h00;
        end else begin
          fr_next.sh_out = q ? {fr_reg.sh_out[3:0], 4'h0} : {fr_reg.sh_out[6:0], 1'b0};
          fr_next.cnt = fr_reg.cnt + 6'h01;
        end
      end
      fsr_pkg::FSR_ST_PARAM: begin
        fr_next.sh_in = sh4;
        fr_next.cnt = fr_reg.cnt + 6'h01;
        if (fr_reg.cmd == fsr_pkg::CMD_SET_PARAM && fr_reg.cnt == fsr_pkg::PARAM_LAST_C0) begin
          cf_next.mode.dsel = sh4[fsr_pkg::P_DSEL_LSB+1:fsr_pkg::P_DSEL_LSB];
          cf_next.mode.wlen = sh4[fsr_pkg::P_WLEN_LSB+1:fsr_pkg::P_WLEN_LSB];
          fr_next.state = fsr_pkg::FSR_ST_IGNORE;
        end else if (fr_reg.cmd == fsr_pkg::CMD_SET_WRAP && fr_reg.cnt == fsr_pkg::PARAM_LAST_WRAP) begin
          // Shares the wrap length field, so the choice survives mode entry.
          cf_next.mode.wlen = sh4[fsr_pkg::W_WLEN_LSB+1:fsr_pkg::W_WLEN_LSB];
          cf_next.mode.wrap_dis = sh4[fsr_pkg::W_DIS_BIT];
          fr_next.state = fsr_pkg::FSR_ST_IGNORE;
        end
      end
      fsr_pkg::FSR_ST_IGNORE: begin
        fr_next.cnt = fr_reg.cnt;
      end
      default: begin
        fr_next.state = fsr_pkg::FSR_ST_IGNORE;
      end
    endcase
  end

  // Per-frame state; deselect returns it to command capture.
  always_ff @(posedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      fr_reg <= '{state: fsr_pkg::FSR_ST_CMD, default: '0};
    end else begin
      fr_reg <= fr_next;
    end
  end

  // Mode state that persists across frames.
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      cf_reg <= '{mode: fsr_pkg::MODE_RST, default: '0};
    end else begin
      cf_reg <= cf_next;
    end
  end

  // ----------------------------------------------------------------
  // Output pins, changed on the falling serial edge
  // ----------------------------------------------------------------
  always_comb begin
    pin_next = '0;
    if (fr_reg.dout_en) begin
      if (cf_reg.mode.four_line_command_mode) begin
        pin_next.io = fr_reg.sh_out[7:4];
        pin_next.oe = 4'hF;
      end else begin
        pin_next.io = {2'h0, fr_reg.sh_out[7], 1'b0};
        pin_next.oe = 4'h2;
      end
    end
  end

  // Pins release as soon as the host deselects.
  always_ff @(negedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign io_out = pin_reg.io;
  assign io_oe_out = pin_reg.oe;
  assign array_addr_out = fr_reg.addr;

  // ----------------------------------------------------------------
  // Core side: reset recovery timer and status mirrors
  // ----------------------------------------------------------------
  // The reset event crosses as a toggle; the mode word is taken only when
  // two late stages agree, so a word caught mid-change is never shown.
  always_comb begin
    core_next = core_reg;
    core_next.tog_s = {core_reg.tog_s[1:0], cf_reg.rst_tog};
    core_next.mode_s1 = cf_reg.mode;
    core_next.mode_s2 = core_reg.mode_s1;
    core_next.mode_s3 = core_reg.mode_s2;
    core_next.soft_rst = 1'b0;
    if (core_reg.mode_s2 == core_reg.mode_s3) begin
      core_next.mode_out = core_reg.mode_s3;
    end
    if (core_reg.tog_s[1] ^ core_reg.tog_s[2]) begin
      core_next.soft_rst = 1'b1;
      core_next.busy = 1'b1;
      if (erase_active_in) begin
        core_next.cnt = fsr_pkg::BUSY_CNT_W'(RST_E_CYCLES - 1);
      end else begin
        core_next.cnt = fsr_pkg::BUSY_CNT_W'(fsr_pkg::RST_CYCLES - 1);
      end
    end else if (core_reg.busy) begin
      if (core_reg.cnt == '0) begin
        core_next.busy = 1'b0;
      end else begin
        core_next.cnt = core_reg.cnt - fsr_pkg::BUSY_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_reg <= '{mode_s1: fsr_pkg::MODE_RST, mode_s2: fsr_pkg::MODE_RST, mode_s3: fsr_pkg::MODE_RST,
                    mode_out: fsr_pkg::MODE_RST, default: '0};
    end else begin
      core_reg <= core_next;
    end
  end

  assign busy_out = core_reg.busy;
  assign soft_reset_out = core_reg.soft_rst;
  assign four_line_command_mode_out = core_reg.mode_out.four_line_command_mode;
  assign dummy_clock_select_out = core_reg.mode_out.dsel;
  assign wrap_length_select_out = core_reg.mode_out.wlen;
  assign wrap_disabled_out = core_reg.mode_out.wrap_dis;

endmodule

/* tb/fsr_checker.sv */
// Concurrent checks on the ports of the flash command block.
`timescale 1ns/100ps
module fsr_checker #(
  parameter int unsigned RST_E_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_oe_out,
  input wire logic busy_out,
  input wire logic soft_reset_out,
  input wire logic four_line_command_mode_out,
  input wire logic [1:0] dummy_clock_select_out,
  input wire logic [1:0] wrap_length_select_out,
  input wire logic wrap_disabled_out
);
  localparam int unsigned LO = (fsr_pkg::RST_CYCLES < RST_E_CYCLES) ? fsr_pkg::RST_CYCLES : RST_E_CYCLES;
  localparam int unsigned HI = ((fsr_pkg::RST_CYCLES > RST_E_CYCLES) ? fsr_pkg::RST_CYCLES : RST_E_CYCLES) + 2;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ------
  // Helper logic
  // ------
  // The recovery lasts thousands of cycles, so its length is counted rather than repeated.
  logic [20:0] busy_len_reg;
  logic [20:0] busy_len_next;
  always_comb begin
    busy_len_next = busy_out ? busy_len_reg + 21'h000001 : 21'h000000;
  end
  // Count register.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_len_reg <= 21'h000000;
    end else begin
      busy_len_reg <= busy_len_next;
    end
  end
  sequence s_pulse;
    soft_reset_out ##1 !soft_reset_out;
  endsequence
  sequence s_defaults;
    ##[0:8] (!four_line_command_mode_out && dummy_clock_select_out == 2'h0 && wrap_length_select_out == 2'h0
      && wrap_disabled_out);
  endsequence
  // ------
  // Assertions
  // ------
  chk_oe_release: assert property (cs_n_in |-> io_oe_out == 4'h0)
    else $error("data pins driven while deselected");
  chk_oe_code: assert property (io_oe_out inside {4'h0, 4'h2, 4'hF})
    else $error("illegal output enable pattern");
  chk_oe_single: assert property (io_oe_out == 4'h2 |-> !four_line_command_mode_out)
    else $error("single-line output in four-line mode");
  chk_oe_quad: assert property (io_oe_out == 4'hF |-> four_line_command_mode_out)
    else $error("four-line output in single-line mode");
  chk_pulse_once: assert property ($rose(soft_reset_out) |-> s_pulse)
    else $error("reset pulse not one cycle");
  chk_reset_defaults: assert property (soft_reset_out |-> s_defaults)
    else $error("mode not back to defaults after reset");
  chk_busy_follows: assert property ($rose(soft_reset_out) |-> ##[0:2] busy_out)
    else $error("no busy after reset");
  chk_busy_cause: assert property ($rose(busy_out) |-> soft_reset_out || $past(soft_reset_out))
    else $error("busy without accepted reset");
  chk_busy_length: assert property ($fell(busy_out) |-> busy_len_reg >= LO && busy_len_reg <= HI)
    else $error("recovery length out of range");
  chk_wrap_kept: assert property ($rose(four_line_command_mode_out) |-> $stable(wrap_length_select_out))
    else $error("wrap length changed on mode entry");
endmodule

/* tb/fsr_host_model.sv */
// Host controller model: makes the serial clock, chip select and data lines.
`timescale 1ns/100ps
module fsr_host_model (
  input wire logic [3:0] dut_io_in,
  input wire logic [3:0] dut_oe_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_line_out
);
  logic [3:0] drv_reg = 4'h0;
  logic [3:0] en_reg = 4'h0;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
  end
  // Released lines show the inverse of the last level, so stale data is never mistaken for valid.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_line_out[i] = dut_oe_in[i] ? dut_io_in[i] : (en_reg[i] ? drv_reg[i] : ~drv_reg[i]);
    end
  end
  // ------
  // Frame tasks
  // ------
  // One clock of 30 ns, well inside every read rate limit; the clock idles low between frames.
  task automatic tick();
    #15 sclk_out = 1'b1;
    #15 sclk_out = 1'b0;
  endtask
  task automatic select();
    cs_n_out = 1'b0;
    #10;
  endtask
  // Every frame is closed by chip select, which also ends a read.
  task automatic deselect();
    #10 cs_n_out = 1'b1;
    en_reg = 4'h0;
    #40;
  endtask
  // Command, address and dummy bits go out MSB first, changed just after the falling edge.
  task automatic send(input logic [31:0] v, input int n, input logic q);
    for (int i = n - 1; i >= 0; i = i - (q ? 4 : 1)) begin
      if (q) begin
        drv_reg = v[i-:4];
        en_reg = 4'hF;
      end else begin
        drv_reg[0] = v[i];
        en_reg = 4'h1;
      end
      tick();
    end
  endtask
  // Data is sampled just before each rising edge.
  task automatic recv(output logic [63:0] r, input int n, input logic q);
    r = 64'h0;
    en_reg = 4'h0;
    for (int i = 0; i < n; i = i + (q ? 4 : 1)) begin
      #15 r = q ? {r[59:0], io_line_out} : {r[62:0], io_line_out[1]};
      sclk_out = 1'b1;
      #15 sclk_out = 1'b0;
    end
  endtask
endmodule

/* tb/flash_secreg_read_mode_reset_bench.sv */
// Self-checking bench for the flash security-read, mode and reset block.
`timescale 1ns/100ps
module flash_secreg_read_mode_reset_bench;
  localparam int unsigned ERASE_CYC = 50;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic erase_reg = 1'b0;
  logic wr_en_reg = 1'b0;
  logic [11:0] wr_addr_reg = 12'h000;
  logic [7:0] wr_data_reg = 8'h00;
  logic sclk, cs_n, busy, srst, four_line_command_mode, wdis;
  logic [3:0] io_line, io_out, io_oe;
  logic [1:0] dsel, wlen;
  logic [23:0] a_addr;
  logic [63:0] rd;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  // The main array answers with the low address byte, so the low byte of every read address is visible.
  fsr_top #(.RST_E_CYCLES(ERASE_CYC)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_line), .io_out(io_out),
    .io_oe_out(io_oe), .array_addr_out(a_addr), .array_data_in(a_addr[7:0]), .erase_active_in(erase_reg),
    .secreg_wr_en_in(wr_en_reg), .secreg_wr_addr_in(wr_addr_reg), .secreg_wr_data_in(wr_data_reg),
    .busy_out(busy), .soft_reset_out(srst), .four_line_command_mode_out(four_line_command_mode),
    .dummy_clock_select_out(dsel), .wrap_length_select_out(wlen), .wrap_disabled_out(wdis)
  );
  fsr_host_model i_host (.dut_io_in(io_out), .dut_oe_in(io_oe), .sclk_out(sclk), .cs_n_out(cs_n),
    .io_line_out(io_line));
  // Core clock and hang guard.
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      final_report();
    end
  end
  // ------
  // Helpers
  // ------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Counts: %0d mismatches in %0d comparisons", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic frame(input logic [31:0] v, input int n, input logic q);
    i_host.select();
    i_host.send(v, n, q);
    i_host.deselect();
    idle(8);
  endtask
  task automatic rd_frame(input logic [31:0] hdr, input int dmy, input int nb, input logic q);
    i_host.select();
    i_host.send(hdr, 32, q);
    i_host.send(32'h0, dmy, q);
    i_host.recv(rd, nb, q);
    i_host.deselect();
    idle(8);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    wr_addr_reg = a;
    wr_data_reg = d;
    wr_en_reg = 1'b1;
    idle(1);
    wr_en_reg = 1'b0;
    // A clock passes with the strobe low, so back-to-back writes never reassign it in one step.
    idle(1);
  endtask
  // Waits for the reset pulse, then counts the recovery cycles.
  task automatic busy_span(output int n);
    n = 0;
    while (srst !== 1'b1 && n < 100) begin
      idle(1);
      n++;
    end
    check(srst, 1'b1);
    n = 0;
    while (busy !== 1'b1 && n < 4) begin
      idle(1);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      idle(1);
      n++;
    end
  endtask
  // ------
  // Scenarios
  // ------
  // Read across the last byte of register one, then an untouched register.
  task automatic t_secread();
    wr(12'h7FF, 8'hA5);
    wr(12'h400, 8'h5A);
    rd_frame({8'h48, 24'h0013FF}, 8, 24, 1'b0);
    check(rd, 64'hA55AFF);
    rd_frame({8'h48, 24'h003155}, 8, 8, 1'b0);
    check(rd, 64'hFF);
  endtask
  // Wrap bits set in single-line mode must survive entry to four-line mode.
  task automatic t_modes();
    i_host.select();
    i_host.send(32'h77, 8, 1'b0);
    i_host.send(32'h00000020, 32, 1'b1);
    i_host.deselect();
    idle(8);
    check({wlen, wdis}, 3'b010);
    frame(32'h38, 8, 1'b0);
    check({four_line_command_mode, wlen, wdis}, 4'b1010);
  endtask
  // Every dummy and wrap code, each read starting on the last byte of its window.
  task automatic t_params();
    int dm[4] = '{4, 4, 6, 8};
    logic [7:0] lo;
    for (int i = 0; i < 4; i++) begin
      frame({16'h0, 8'hC0, 2'b00, i[1:0], 2'b00, i[1:0]}, 16, 1'b1);
      check({dsel, wlen}, {i[1:0], i[1:0]});
      lo = 8'((8 << i) - 1);
      rd_frame({8'h0C, 16'h0001, lo}, 4 * dm[i], 16, 1'b1);
      check(rd, {48'h0, lo, 8'h00});
    end
    // Plain fast read from the same window end runs on past it.
    rd_frame({8'h0B, 16'h0001, 8'h3F}, 32, 16, 1'b1);
    check(rd, {48'h0, 8'h3F, 8'h40});
  endtask
  // Leaving four-line mode keeps the wrap length; a lone reset code is ignored.
  task automatic t_exit();
    frame(32'hFF, 8, 1'b1);
    check({four_line_command_mode, wlen}, 3'b011);
    frame(32'h99, 8, 1'b0);
    check({busy, wlen}, 3'b011);
  endtask
  // Reset pair; a command sent during recovery must be ignored.
  task automatic t_reset(input logic q, input logic er, input int unsigned lim);
    int n;
    erase_reg = er;
    check(busy, 1'b0);
    frame(32'h66, 8, q);
    fork
      begin
        frame(32'h99, 8, q);
        frame(32'h38, 8, 1'b0);
      end
      busy_span(n);
    join
    erase_reg = 1'b0;
    check(n >= lim && n <= lim + 2, 1'b1);
    check({four_line_command_mode, dsel, wlen, wdis}, 6'b000001);
  endtask
  // Main sequence.
  initial begin
    idle(4);
    rst_in = 1'b0;
    idle(2);
    t_secread();
    t_modes();
    t_params();
    t_exit();
    t_reset(1'b0, 1'b0, fsr_pkg::RST_CYCLES);
    frame(32'h38, 8, 1'b0);
    t_reset(1'b1, 1'b1, ERASE_CYC);
    final_report();
  end
endmodule
bind fsr_top fsr_checker #(.RST_E_CYCLES(RST_E_CYCLES)) i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .io_oe_out(io_oe_out), .busy_out(busy_out),
  .soft_reset_out(soft_reset_out), .four_line_command_mode_out(four_line_command_mode_out),
  .dummy_clock_select_out(dummy_clock_select_out), .wrap_length_select_out(wrap_length_select_out),
  .wrap_disabled_out(wrap_disabled_out)
);
